// [logic/mars_defs.vh]
// constants of the motor algorithm status readback bank
// assumes inclusion by bare name from the design files of this block
`ifndef MARS_DEFS_VH
`define MARS_DEFS_VH

// ---------------------------------------------------------------
// register offsets, byte addressed as printed
// ---------------------------------------------------------------
`define MARS_ADDR_W            8
`define MARS_OFS_ALGORITHM_STATUS_WORD   8'hE4
`define MARS_OFS_MOTOR_PARAM   8'hE6
`define MARS_OFS_MEAS_STATUS   8'hE8
`define MARS_OFS_TORQUE_GAIN   8'hF0
`define MARS_OFS_VELOCITY_GAIN 8'hF2

// ---------------------------------------------------------------
// field layout
// ---------------------------------------------------------------
`define MARS_DATA_W            32
`define MARS_GAIN_W            10
`define MARS_HALF_W            16
`define MARS_MOD_W             16
`define MARS_DUTY_W            12
`define MARS_BEMF_W            8
`define MARS_FREQ_W            4
`define MARS_GAIN_PAD_W        6
`define MARS_MOD_MSB           31
`define MARS_MOD_LSB           16
`define MARS_DUTY_MSB          15
`define MARS_DUTY_LSB          4
`define MARS_READY_BIT         2
`define MARS_BEMF_MSB          23
`define MARS_BEMF_LSB          16
`define MARS_KE_DONE_BIT       29
`define MARS_MECH_DONE_BIT     28
`define MARS_FREQ_MSB          27
`define MARS_FREQ_LSB          24
`define MARS_FLAG_COUNT        2
`define MARS_FLAG_KE           0
`define MARS_FLAG_MECH         1

// ---------------------------------------------------------------
// reset values
// ---------------------------------------------------------------
`define MARS_RESET_WORD        32'h00000000
`define MARS_RESET_BIT         1'b0

`endif

// [logic/mars_done_flag.v]
// one completion flag of the parameter measurement routine
// assumes arm and done are one-cycle pulses on clk from the algorithm side
`timescale 1ns/1ps
module mars_done_flag (
    clk,
    reset,
    arm,
    done,
    flag
);
    input  wire clk;
    input  wire reset;
    input  wire arm;
    input  wire done;
    output reg  flag;

    // ---------------------------------------------------------------
    // arming clears the flag, completion sets it; set wins a tie
    // ---------------------------------------------------------------
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            flag <= 1'b0;
        end else if (done) begin
            flag <= 1'b1;
        end else if (arm) begin
            flag <= 1'b0;
        end
    end
endmodule

// [logic/mars_status_bank.v]
// read-only status bank of the motor algorithm: loop gains, modulation,
// duty command, ready flag and parameter measurement results
// assumes all algorithm inputs come from logic on clk; host reads and
// writes arrive as one-cycle strobes on clk from the host interface logic
//
// Summary of operation
// - torque loop integral gain in upper half, proportional in lower, 10 bits each
// - velocity loop integral gain in upper half, proportional in lower, 10 bits each
// - modulation index in bits 31-16 of algorithm status; 32768 is full modulation
// - input duty command in bits 15-4; 4095 is full duty
// - ready flag bit 2 low while defaults copy, high once host may control
// - measured back-emf constant in bits 23-16 of motor parameter word
// - bit 29 low until requested back-emf measurement completes, then high
// - bit 28 low until requested mechanical measurement completes, then high
// - recommended switching frequency code in bits 27-24, same coding as pwm setting
`timescale 1ns/1ps
`include "mars_defs.vh"
module mars_status_bank (
    clk,
    reset,
    rd_en,
    rd_addr,
    rd_data,
    rd_valid,
    rd_hit,
    wr_en,
    wr_addr,
    wr_ack,
    torque_integral_gain,
    torque_proportional_gain,
    velocity_integral_gain,
    velocity_proportional_gain,
    modulation_index,
    duty_command,
    defaults_copied,
    measured_back_emf_constant,
    back_emf_constant_load,
    recommended_switching_freq,
    switching_freq_load,
    measurement_start,
    back_emf_measure_enable,
    mechanical_measure_enable,
    back_emf_measure_finish,
    mechanical_measure_finish,
    back_emf_measure_done,
    mechanical_measure_done,
    system_ready_flag
);
    input  wire                       clk;
    input  wire                       reset;
    input  wire                       rd_en;
    input  wire [`MARS_ADDR_W-1:0]    rd_addr;
    output reg  [`MARS_DATA_W-1:0]    rd_data;
    output reg                        rd_valid;
    output reg                        rd_hit;
    input  wire                       wr_en;
    input  wire [`MARS_ADDR_W-1:0]    wr_addr;
    output reg                        wr_ack;
    input  wire [`MARS_GAIN_W-1:0]    torque_integral_gain;
    input  wire [`MARS_GAIN_W-1:0]    torque_proportional_gain;
    input  wire [`MARS_GAIN_W-1:0]    velocity_integral_gain;
    input  wire [`MARS_GAIN_W-1:0]    velocity_proportional_gain;
    input  wire [`MARS_MOD_W-1:0]     modulation_index;
    input  wire [`MARS_DUTY_W-1:0]    duty_command;
    input  wire                       defaults_copied;
    input  wire [`MARS_BEMF_W-1:0]    measured_back_emf_constant;
    input  wire                       back_emf_constant_load;
    input  wire [`MARS_FREQ_W-1:0]    recommended_switching_freq;
    input  wire                       switching_freq_load;
    input  wire                       measurement_start;
    input  wire                       back_emf_measure_enable;
    input  wire                       mechanical_measure_enable;
    input  wire                       back_emf_measure_finish;
    input  wire                       mechanical_measure_finish;
    output wire                       back_emf_measure_done;
    output wire                       mechanical_measure_done;
    output reg                        system_ready_flag;

    // ---------------------------------------------------------------
    // live copies of the algorithm values
    // ---------------------------------------------------------------
    reg  [`MARS_GAIN_W-1:0]           torque_ki;
    reg  [`MARS_GAIN_W-1:0]           torque_kp;
    reg  [`MARS_GAIN_W-1:0]           velocity_ki;
    reg  [`MARS_GAIN_W-1:0]           velocity_kp;
    reg  [`MARS_MOD_W-1:0]            modulation;
    reg  [`MARS_DUTY_W-1:0]           duty;
    reg  [`MARS_BEMF_W-1:0]           bemf_const;
    reg  [`MARS_FREQ_W-1:0]           freq_code;
    wire [`MARS_FLAG_COUNT-1:0]       flag_arm;
    wire [`MARS_FLAG_COUNT-1:0]       flag_finish;
    wire [`MARS_FLAG_COUNT-1:0]       flag_state;
    reg  [`MARS_DATA_W-1:0]           next_rd_data;
    reg                               next_rd_hit;

    always @(posedge clk or posedge reset) begin
        if (reset) begin
            torque_ki   <= {`MARS_GAIN_W{1'b0}};
            torque_kp   <= {`MARS_GAIN_W{1'b0}};
            velocity_ki <= {`MARS_GAIN_W{1'b0}};
            velocity_kp <= {`MARS_GAIN_W{1'b0}};
            modulation  <= {`MARS_MOD_W{1'b0}};
            duty        <= {`MARS_DUTY_W{1'b0}};
        end else begin
            torque_ki   <= torque_integral_gain;
            torque_kp   <= torque_proportional_gain;
            velocity_ki <= velocity_integral_gain;
            velocity_kp <= velocity_proportional_gain;
            modulation  <= modulation_index;
            duty        <= duty_command;
        end
    end

    // ---------------------------------------------------------------
    // ready flag and measurement results
    // ---------------------------------------------------------------
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            system_ready_flag <= `MARS_RESET_BIT;
        end else begin
            system_ready_flag <= defaults_copied;
        end
    end

    // results hold between loads; only back_emf_constant_load or switching_freq_load loads them
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            bemf_const <= {`MARS_BEMF_W{1'b0}};
            freq_code  <= {`MARS_FREQ_W{1'b0}};
        end else begin
            if (back_emf_constant_load) begin
                bemf_const <= measured_back_emf_constant;
            end
            if (switching_freq_load) begin
                freq_code <= recommended_switching_freq;
            end
        end
    end

    // a start with a measurement enabled arms that flag back to not done
    assign flag_arm[`MARS_FLAG_KE]      = measurement_start & back_emf_measure_enable;
    assign flag_arm[`MARS_FLAG_MECH]    = measurement_start & mechanical_measure_enable;
    assign flag_finish[`MARS_FLAG_KE]   = back_emf_measure_finish;
    assign flag_finish[`MARS_FLAG_MECH] = mechanical_measure_finish;

    genvar fi;
    generate
        for (fi = 0; fi < `MARS_FLAG_COUNT; fi = fi + 1) begin : g_flag
            mars_done_flag u_flag (
                .clk   (clk),
                .reset (reset),
                .arm   (flag_arm[fi]),
                .done  (flag_finish[fi]),
                .flag  (flag_state[fi])
            );
        end
    endgenerate

    assign back_emf_measure_done   = flag_state[`MARS_FLAG_KE];
    assign mechanical_measure_done = flag_state[`MARS_FLAG_MECH];

    // ---------------------------------------------------------------
    // read decode; unmapped offsets and reserved bits return zero
    // ---------------------------------------------------------------
    always @* begin
        next_rd_data = `MARS_RESET_WORD;
        next_rd_hit  = 1'b1;
        case (rd_addr)
            `MARS_OFS_TORQUE_GAIN: begin
                next_rd_data = {{`MARS_GAIN_PAD_W{1'b0}}, torque_ki,
                                {`MARS_GAIN_PAD_W{1'b0}}, torque_kp};
            end
            `MARS_OFS_VELOCITY_GAIN: begin
                next_rd_data = {{`MARS_GAIN_PAD_W{1'b0}}, velocity_ki,
                                {`MARS_GAIN_PAD_W{1'b0}}, velocity_kp};
            end
            `MARS_OFS_ALGORITHM_STATUS_WORD: begin
                next_rd_data[`MARS_MOD_MSB:`MARS_MOD_LSB]   = modulation;
                next_rd_data[`MARS_DUTY_MSB:`MARS_DUTY_LSB] = duty;
                next_rd_data[`MARS_READY_BIT]               = system_ready_flag;
            end
            `MARS_OFS_MOTOR_PARAM: begin
                next_rd_data[`MARS_BEMF_MSB:`MARS_BEMF_LSB] = bemf_const;
            end
            `MARS_OFS_MEAS_STATUS: begin
                next_rd_data[`MARS_KE_DONE_BIT]   = flag_state[`MARS_FLAG_KE];
                next_rd_data[`MARS_MECH_DONE_BIT] = flag_state[`MARS_FLAG_MECH];
                next_rd_data[`MARS_FREQ_MSB:`MARS_FREQ_LSB] = freq_code;
            end
            default: begin
                next_rd_hit = 1'b0;
            end
        endcase
    end

    // ---------------------------------------------------------------
    // read answer one cycle after the strobe; data held until next read
    // ---------------------------------------------------------------
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            rd_data  <= `MARS_RESET_WORD;
            rd_valid <= 1'b0;
            rd_hit   <= 1'b0;
        end else begin
            rd_valid <= rd_en;
            if (rd_en) begin
                rd_data <= next_rd_data;
                rd_hit  <= next_rd_hit;
            end
        end
    end

    // ---------------------------------------------------------------
    // writes are acknowledged and dropped; nothing here is writable
    // ---------------------------------------------------------------
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            wr_ack <= 1'b0;
        end else begin
            wr_ack <= wr_en & (wr_addr == wr_addr);
        end
    end
endmodule

// [sim/mars_status_bank_sva.sv]
// assertions on the ports of the status bank
// assumes binding onto mars_status_bank, one clock domain
`timescale 1ns/1ps
module mars_status_bank_sva (
    input wire        clk,
    input wire        reset,
    input wire        rd_en,
    input wire [7:0]  rd_addr,
    input wire [31:0] rd_data,
    input wire        rd_valid,
    input wire        rd_hit,
    input wire        wr_en,
    input wire        wr_ack,
    input wire [9:0]  torque_integral_gain,
    input wire [9:0]  torque_proportional_gain,
    input wire [15:0] modulation_index,
    input wire [11:0] duty_command,
    input wire        defaults_copied,
    input wire        measurement_start,
    input wire        back_emf_measure_enable,
    input wire        mechanical_measure_enable,
    input wire        back_emf_measure_finish,
    input wire        mechanical_measure_finish,
    input wire        back_emf_measure_done,
    input wire        mechanical_measure_done,
    input wire        system_ready_flag
);
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    AST_RD_ANSWER: assert property (rd_en |=> rd_valid)
        else $error("read not answered");
    AST_RD_HOLD: assert property (!rd_en |=> !rd_valid && $stable(rd_data))
        else $error("read data moved without read");
    AST_WR_ACK: assert property (wr_en |=> wr_ack)
        else $error("write not acknowledged");
    AST_UNMAPPED: assert property (rd_en && !(rd_addr inside {8'hE4, 8'hE6, 8'hE8, 8'hF0,
        8'hF2}) |=> rd_data == 32'h0 && !rd_hit) else $error("unmapped read not zero");
    AST_ALGO_WORD: assert property (rd_en && rd_addr == 8'hE4 && !$past(reset) |=>
        rd_data == {$past(modulation_index, 2), $past(duty_command, 2), 1'b0,
        $past(defaults_copied, 2), 2'b00}) else $error("algorithm status word wrong");
    AST_TORQUE_WORD: assert property (rd_en && rd_addr == 8'hF0 && !$past(reset) |=>
        rd_data == {6'h0, $past(torque_integral_gain, 2), 6'h0,
        $past(torque_proportional_gain, 2)}) else $error("torque gain word wrong");
    AST_BEMF_RSVD: assert property (rd_en && rd_addr == 8'hE6 |=>
        rd_data[31:24] == 8'h0 && rd_data[15:0] == 16'h0) else $error("reserved bits set");
    AST_MEAS_WORD: assert property (rd_en && rd_addr == 8'hE8 |=>
        rd_data[31:28] == {2'b00, $past(back_emf_measure_done), $past(mechanical_measure_done)}
        && rd_data[23:0] == 24'h0) else $error("measurement status word wrong");
    AST_READY: assert property (!$past(reset) |->
        system_ready_flag == $past(defaults_copied)) else $error("ready flag wrong");
    AST_KE_SET: assert property (back_emf_measure_finish |=> back_emf_measure_done)
        else $error("back-emf flag not set");
    AST_KE_CLEAR: assert property (measurement_start && back_emf_measure_enable &&
        !back_emf_measure_finish |=> !back_emf_measure_done) else $error("flag not cleared");
    AST_MECH_SET: assert property (mechanical_measure_finish |=> mechanical_measure_done)
        else $error("mechanical flag not set");
    AST_MECH_HOLD: assert property (!mechanical_measure_finish &&
        !(measurement_start && mechanical_measure_enable) |=> $stable(mechanical_measure_done))
        else $error("mechanical flag moved");
endmodule
bind mars_status_bank mars_status_bank_sva mars_status_bank_sva_i (.*);

// [sim/mars_host_model.sv]
// host model: register reads, writes and measurement starts
// assumes the status bank on the same clk; changes at falling edges
`timescale 1ns/1ps
module mars_host_model (
    input  wire       clk,
    input  wire       rd_valid,
    input  wire       wr_ack,
    output reg        rd_en = 1'b0,
    output reg  [7:0] rd_addr = 8'h00,
    output reg        wr_en = 1'b0,
    output reg  [7:0] wr_addr = 8'h00,
    output reg        measurement_start = 1'b0,
    output reg        back_emf_measure_enable = 1'b0,
    output reg        mechanical_measure_enable = 1'b0,
    output reg        hung = 1'b0
);
    task do_read(input logic [7:0] a);
        begin
            @(negedge clk);
            rd_en = 1'b1;
            rd_addr = a;
            @(negedge clk);
            rd_en = 1'b0;
            rd_addr = ~a;
            if (rd_valid !== 1'b1) hung = 1'b1;
        end
    endtask
    task do_write(input logic [7:0] a);
        begin
            // reserved offsets are never written
            if (a inside {8'hE4, 8'hE6, 8'hE8, 8'hF0, 8'hF2}) begin
                @(negedge clk);
                wr_en = 1'b1;
                wr_addr = a;
                @(negedge clk);
                wr_en = 1'b0;
                if (wr_ack !== 1'b1) hung = 1'b1;
            end
        end
    endtask
    task do_start(input logic go, input logic ke, input logic me);
        begin
            @(negedge clk);
            measurement_start = go;
            back_emf_measure_enable = ke;
            mechanical_measure_enable = me;
            @(negedge clk);
            measurement_start = 1'b0;
        end
    endtask
endmodule

// [sim/testbench.sv]
// self-checking bench of the status bank driven by the host model
// assumes the design files and the checker are compiled alongside
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin cmp_count++; if ((got) !== (ex)) begin n_errors++; \
    $display("MISMATCH %s exp %h got %h", nm, ex, got); end end
module testbench;
    logic        clk = 1'b0, reset = 1'b1, rd_en, wr_en, rd_valid, rd_hit, wr_ack, hung;
    logic [7:0]  rd_addr, wr_addr, measured_back_emf_constant, bemf_e;
    logic [31:0] rd_data;
    logic [9:0]  torque_integral_gain, torque_proportional_gain;
    logic [9:0]  velocity_integral_gain, velocity_proportional_gain;
    logic [15:0] modulation_index;
    logic [11:0] duty_command;
    logic [3:0]  recommended_switching_freq, freq_e;
    logic        defaults_copied, back_emf_constant_load, switching_freq_load, ke_m, me_m;
    logic        measurement_start, back_emf_measure_enable, mechanical_measure_enable;
    logic        back_emf_measure_finish, mechanical_measure_finish;
    logic        back_emf_measure_done, mechanical_measure_done, system_ready_flag;
    logic [6:0]  ev;
    logic [32:0] expq[$], exp_w;
    logic [7:0]  offs[7] = '{8'hE4, 8'hE6, 8'hE8, 8'hF0, 8'hF2, 8'hE0, 8'hFF};
    int          n_errors = 0, cmp_count = 0;
    mars_status_bank mars_status_bank_i (.*);
    mars_host_model  mars_host_model_i (.*);
    always #2 clk = ~clk;
    task report_and_stop;
        begin
            // a read still owed an answer at the end counts as a mismatch
            if (expq.size() != 0) n_errors++;
            $display("TB: %0d compares, %0d errors", cmp_count, n_errors);
            if (n_errors == 0 && cmp_count > 0) $display("TB: PASS");
            else $display("TB: FAIL");
            $finish;
        end
    endtask
    function logic [32:0] word(input logic [7:0] a);
        case (a)
            8'hE4: word = {1'b1, modulation_index, duty_command, 1'b0, defaults_copied, 2'b0};
            8'hE6: word = {1'b1, 8'h0, bemf_e, 16'h0};
            8'hE8: word = {1'b1, 2'b0, ke_m, me_m, freq_e, 24'h0};
            8'hF0: word = {1'b1, 6'h0, torque_integral_gain, 6'h0, torque_proportional_gain};
            8'hF2: word = {1'b1, 6'h0, velocity_integral_gain, 6'h0, velocity_proportional_gain};
            default: word = 33'h0;
        endcase
    endfunction
    task read_all;
        for (int k = 0; k < 7; k++) begin
            expq.push_back(word(offs[k]));
            mars_host_model_i.do_read(offs[k]);
        end
    endtask
    task zero_inputs;
        {torque_integral_gain, torque_proportional_gain, velocity_integral_gain} = '0;
        {velocity_proportional_gain, modulation_index, duty_command, defaults_copied} = '0;
        {measured_back_emf_constant, back_emf_constant_load, recommended_switching_freq} = '0;
        {switching_freq_load, back_emf_measure_finish, mechanical_measure_finish} = '0;
        {ke_m, me_m, bemf_e, freq_e} = '0;
    endtask
    task pulse;
        begin
            @(negedge clk);
            {torque_integral_gain, torque_proportional_gain, velocity_integral_gain} = 30'($urandom);
            {velocity_proportional_gain, duty_command, defaults_copied} = 23'($urandom);
            {modulation_index, measured_back_emf_constant} = 24'($urandom);
            recommended_switching_freq = 4'($urandom);
            {back_emf_constant_load, switching_freq_load} = ev[6:5];
            {back_emf_measure_finish, mechanical_measure_finish} = ev[4:3];
            @(negedge clk);
            {back_emf_constant_load, switching_freq_load} = 2'b00;
            {back_emf_measure_finish, mechanical_measure_finish} = 2'b00;
        end
    endtask
    always @(posedge clk) begin
        if (rd_valid === 1'b1) begin
            exp_w = (expq.size() > 0) ? expq.pop_front() : 33'h1FFFFFFFF;
            `CHK("read word", exp_w, {rd_hit, rd_data})
        end
    end
    always @(posedge hung) begin
        n_errors++;
        report_and_stop();
    end
    initial begin
        zero_inputs();
        void'($urandom(99444));
        repeat (2) @(negedge clk);
        reset = 1'b0;
        read_all();
        for (int i = 0; i < 3; i++) begin
            repeat (16) begin
                ev = 7'($urandom);
                fork
                    mars_host_model_i.do_start(ev[2], ev[1], ev[0]);
                    pulse();
                join
                if (ev[6]) bemf_e = measured_back_emf_constant;
                if (ev[5]) freq_e = recommended_switching_freq;
                ke_m = ev[4] | (ke_m & !(ev[2] & ev[1]));
                me_m = ev[3] | (me_m & !(ev[2] & ev[0]));
                `CHK("back-emf flag", ke_m, back_emf_measure_done)
                `CHK("mechanical flag", me_m, mechanical_measure_done)
                `CHK("ready flag", defaults_copied, system_ready_flag)
                mars_host_model_i.do_write(offs[$urandom % 5]);
                read_all();
            end
            @(negedge clk);
            reset = 1'b1;
            zero_inputs();
            @(negedge clk);
            reset = 1'b0;
            read_all();
        end
        repeat (2) @(negedge clk);
        report_and_stop();
    end
endmodule
